//--- pmoc_ctrl.sv
// module: rail on/off control, fault clearing, write lock, default store and status
// Notes on behaviour
// R1 - page commands act on selected rail or all
// R2 - decode on/off byte from its top bits
// R3 - all-rails soft commands sequence rails in order
// R4 - asserted enable pin overrides commanded off
// R5 - enable pin action uses programmed on/off delays; code skips the off delay when the rail's last command was immediate off
// R6 - faults switch rail off, optional retry
// R7 - host alone: same order, ignore enable pins
// R8 - page, on/off, lock level never stored
// R9 - clear faults of selected rail or all
// R10 - off indication tracks live state always
// R11 - lock level gates bus writes
// R12 - invalid command sets communications fault
// R13 - clear faults works at any lock level
// R14 - store copies parameters, startup reloads them
// R15 - store finishes within 70 ms
// R16 - host must not write during store
// R17 - fixed feature report byte
// R18 - fault summary byte layout
// R19 - temperature and comms bits page independent
// R20 - other-fault bit excludes manufacturer summary
// R21 - locked-out writes leave target unchanged
`timescale 1ns/1ps
module pmoc_ctrl
  import pmoc_pkg::*;
#(
  parameter int NUM_RAILS    = 4,
  parameter int DLY_STEP_CYC = PMOC_DLY_STEP_CYC,
  parameter int STORE_CYC    = PMOC_STORE_CYC
) (
  // clock and resets
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 por_in,
  // command port
  input  wire logic                 cmd_valid_in,
  input  wire logic                 cmd_write_in,
  input  wire logic [7:0]           cmd_code_in,
  input  wire logic [7:0]           cmd_data_in,
  // read answer
  output logic                      rd_valid_out,
  output logic [7:0]                rd_data_out,
  // pins and configuration
  input  wire logic [NUM_RAILS-1:0] rail_enable_pins_in,
  input  wire logic                 pins_honoured_in,
  input  wire logic                 seq_support_in,
  input  wire logic                 retry_en_in,
  // live fault inputs
  input  wire logic [NUM_RAILS-1:0] ov_fault_in,
  input  wire logic [NUM_RAILS-1:0] oc_fault_in,
  input  wire logic [NUM_RAILS-1:0] other_fault_in,
  input  wire logic                 temp_fault_in,
  // rail and store state
  output logic [NUM_RAILS-1:0]      rail_enable_out,
  output logic [NUM_RAILS-1:0]      rail_off_out,
  output logic                      store_busy_out,
  output logic                      stored_out
);

  localparam int IDX_W = (NUM_RAILS > 1) ? $clog2(NUM_RAILS) : 1;

  // ==========================================================
  // state
  logic [7:0]            page_q;
  logic [7:0]            wp_q;
  logic [7:0]            dly_q;
  logic [7:0]            nv_dly_q;
  logic                  nv_valid_q;
  logic [NUM_RAILS-1:0]  op_on_q;
  logic [NUM_RAILS-1:0]  op_imm_q;
  logic [NUM_RAILS-1:0]  seq_q;
  logic [NUM_RAILS-1:0]  ov_q;
  logic [NUM_RAILS-1:0]  oc_q;
  logic [NUM_RAILS-1:0]  oth_q;
  logic                  temp_q;
  logic                  cml_q;
  logic                  store_busy_q;
  logic [PMOC_CNT_W-1:0] store_cnt_q;
  logic                  rd_valid_q;
  logic [7:0]            rd_data_q;
  logic [NUM_RAILS-1:0]  rail_en_q;
  logic [NUM_RAILS-1:0]  rail_off_q;

  // combinational
  logic                  wr;
  logic                  rd;
  logic                  wr_ok;
  logic                  bad;
  logic                  data_ok;
  logic                  code_rd_ok;
  logic [NUM_RAILS-1:0]  sel;
  logic [NUM_RAILS-1:0]  on_w;
  logic [NUM_RAILS-1:0]  seq_e;
  logic [NUM_RAILS-1:0]  go_on;
  logic [NUM_RAILS-1:0]  go_off;
  logic [NUM_RAILS-1:0]  want;
  logic [NUM_RAILS-1:0]  block;
  logic [NUM_RAILS-1:0]  clr_sel;
  logic                  clr_cmd;
  logic                  store_go;
  logic [7:0]            status;
  logic [7:0]            op_rd;
  logic [IDX_W-1:0]      rd_idx;
  logic [1:0]            op_top;

  // ==========================================================
  // helpers
  // writes that the lock level lets through
  function automatic logic wp_allows(input logic [7:0] lvl, input logic [7:0] code);
    case (lvl)
      PMOC_WP_ONLY: return code == PMOC_CODE_WP;
      PMOC_WP_OPPG: return (code == PMOC_CODE_WP) || (code == PMOC_CODE_OP) ||
                           (code == PMOC_CODE_PAGE);
      PMOC_WP_VREF: return (code == PMOC_CODE_WP) || (code == PMOC_CODE_OP) ||
                           (code == PMOC_CODE_PAGE) || (code == PMOC_CODE_VREF);
      default:      return 1'b1;
    endcase
  endfunction : wp_allows

  // rails addressed by a page value
  function automatic logic [NUM_RAILS-1:0] page_mask(input logic [7:0] pg);
    if (pg == PMOC_PAGE_ALL) begin
      return '1;
    end
    return NUM_RAILS'(1) << pg;
  endfunction : page_mask

  // page value is a rail or all rails
  function automatic logic page_valid(input logic [7:0] pg);
    return (pg == PMOC_PAGE_ALL) || (32'(pg) < NUM_RAILS);
  endfunction : page_valid

  // delay field to clock cycles
  function automatic logic [PMOC_CNT_W-1:0] dly_cyc(input logic [2:0] f);
    return PMOC_CNT_W'(32'(f) * DLY_STEP_CYC);
  endfunction : dly_cyc

  // ==========================================================
  // command decode
  assign wr      = cmd_valid_in && cmd_write_in;
  assign rd      = cmd_valid_in && !cmd_write_in;
  assign sel     = page_mask(page_q); // R1
  assign op_top  = cmd_data_in[PMOC_OP_TOP_HI:PMOC_OP_TOP_LO];    // R2

  // data check, lock check and invalid flag
  always_comb begin
    data_ok    = 1'b0;
    code_rd_ok = 1'b1;
    case (cmd_code_in)
      PMOC_CODE_PAGE:  data_ok = page_valid(cmd_data_in);
      PMOC_CODE_OP:    data_ok = (op_top == PMOC_OP_IMM) || (op_top == PMOC_OP_SOFT) ||
                                 ((op_top == PMOC_OP_ON) &&
                                  (cmd_data_in[PMOC_OP_MID_HI:PMOC_OP_MID_LO] ==
                                   PMOC_OP_MID_ON)); // R2
      PMOC_CODE_WP:    data_ok = (cmd_data_in == PMOC_WP_ONLY) ||
                                 (cmd_data_in == PMOC_WP_OPPG) ||
                                 (cmd_data_in == PMOC_WP_VREF) ||
                                 (cmd_data_in == PMOC_WP_NONE);
      PMOC_CODE_CLR:   data_ok = 1'b1;
      PMOC_CODE_STORE: data_ok = 1'b1;
      PMOC_CODE_DLY:   data_ok = 1'b1;
      PMOC_CODE_CAP:   data_ok = 1'b0;
      PMOC_CODE_STAT:  data_ok = 1'b0;
      default:         code_rd_ok = 1'b0;
    endcase
  end

  // clear faults bypasses the lock; blocked writes are dropped
  assign wr_ok = wr && data_ok &&
                 ((cmd_code_in == PMOC_CODE_CLR) || wp_allows(wp_q, cmd_code_in)); // R11 R13 R21
  assign bad   = (wr && !wr_ok) ||
                 (rd && (!code_rd_ok || (cmd_code_in == PMOC_CODE_CLR) ||
                         (cmd_code_in == PMOC_CODE_STORE))); // R12
  assign clr_cmd  = wr_ok && (cmd_code_in == PMOC_CODE_CLR);
  assign clr_sel  = {NUM_RAILS{clr_cmd}} & sel; // R9
  assign store_go = wr_ok && (cmd_code_in == PMOC_CODE_STORE) && !store_busy_q;

  // ==========================================================
  // page selector, not part of the default store
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      page_q <= PMOC_PAGE_RESET; // R8
    end else if (wr_ok && (cmd_code_in == PMOC_CODE_PAGE)) begin
      page_q <= cmd_data_in; // R1
    end
  end

  // lock level, not part of the default store
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wp_q <= PMOC_WP_RESET; // R8
    end else if (wr_ok && (cmd_code_in == PMOC_CODE_WP)) begin
      wp_q <= cmd_data_in; // R11
    end
  end

  // on/off command per rail, not part of the default store
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      op_on_q  <= {NUM_RAILS{PMOC_OP_RESET[PMOC_OP_TOP_HI:PMOC_OP_TOP_LO] == PMOC_OP_ON}}; // R8
      op_imm_q <= '0;
      seq_q    <= '1;
    end else if (wr_ok && (cmd_code_in == PMOC_CODE_OP)) begin
      for (int i = 0; i < NUM_RAILS; i++) begin
        if (sel[i]) begin
          op_on_q[i]  <= (op_top == PMOC_OP_ON); // R2
          op_imm_q[i] <= (op_top == PMOC_OP_IMM);
          seq_q[i]    <= (page_q == PMOC_PAGE_ALL) && (op_top != PMOC_OP_IMM);  // R3
        end
      end
    end
  end

  // delay setting, reloaded from the default store at startup
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dly_q <= nv_dly_q; // R14
    end else if (wr_ok && (cmd_code_in == PMOC_CODE_DLY) && !store_busy_q) begin
      dly_q <= cmd_data_in; // R16
    end
  end

  // default store, survives all but power-on
  always_ff @(posedge clk_in) begin
    if (por_in) begin
      nv_dly_q   <= PMOC_DLY_RESET;
      nv_valid_q <= 1'b0;
    end else if (store_go) begin
      nv_dly_q   <= dly_q; // R14
      nv_valid_q <= 1'b1;
    end
  end

  // store write time
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      store_busy_q <= 1'b0;
      store_cnt_q  <= '0;
    end else if (store_go) begin
      store_busy_q <= 1'b1;
      store_cnt_q  <= PMOC_CNT_W'(STORE_CYC - 1); // R15
    end else if (store_busy_q) begin
      if (store_cnt_q == '0) begin
        store_busy_q <= 1'b0;
      end else begin
        store_cnt_q <= store_cnt_q - 1'b1;
      end
    end
  end

  // ==========================================================
  // latched faults, a new event beats a clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ov_q   <= '0;
      oc_q   <= '0;
      oth_q  <= '0;
      temp_q <= 1'b0;
      cml_q  <= 1'b0;
    end else begin
      ov_q   <= ov_fault_in | (ov_q & ~clr_sel); // R9
      oc_q   <= oc_fault_in | (oc_q & ~clr_sel);
      oth_q  <= other_fault_in | (oth_q & ~clr_sel); // R20
      temp_q <= temp_fault_in | (temp_q & !clr_cmd);
      cml_q  <= bad | (cml_q & !clr_cmd); // R12
    end
  end

  // ==========================================================
  // rail control
  assign block = ov_fault_in | oc_fault_in | other_fault_in | {NUM_RAILS{temp_fault_in}} |
                 ({NUM_RAILS{!retry_en_in}} &
                  (ov_q | oc_q | oth_q | {NUM_RAILS{temp_q}})); // R6

  // ordered start low to high, ordered stop high to low
  assign seq_e  = seq_q & {NUM_RAILS{seq_support_in}}; // R3
  assign go_on  = ~seq_e | {on_w[NUM_RAILS-2:0], 1'b1};                         // R3
  assign go_off = ~seq_e | {1'b1, ~on_w[NUM_RAILS-1:1]};                        // R3

  // commanded wish plus enable pin override
  assign want = (op_on_q & go_on) | (~op_on_q & on_w & ~go_off) |
                ({NUM_RAILS{pins_honoured_in}} & rail_enable_pins_in); // R4

  // one sequencer per rail
  for (genvar gi = 0; gi < NUM_RAILS; gi++) begin : g_rail
    pmoc_rail_if rif ();
    assign rif.want     = want[gi];
    assign rif.imm_off  = op_imm_q[gi];
    assign rif.block    = block[gi];
    assign rif.ton_cyc  = dly_cyc(dly_q[PMOC_DLY_ON_HI:PMOC_DLY_ON_LO]);       // R5
    assign rif.toff_cyc = dly_cyc(dly_q[PMOC_DLY_OFF_HI:PMOC_DLY_OFF_LO]);     // R5
    assign on_w[gi]     = rif.is_on;
    pmoc_rail u_rail (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .rif      (rif.rail)
    );
  end

  // ==========================================================
  // fault summary, page bits ORed over selected rails
  always_comb begin
    status                = '0;
    status[PMOC_ST_OFF]   = |(sel & ~on_w); // R10 R18
    status[PMOC_ST_OV]    = |(sel & ov_q); // R18
    status[PMOC_ST_OC]    = |(sel & oc_q);
    status[PMOC_ST_TEMP]  = temp_q; // R19
    status[PMOC_ST_CML]   = cml_q;
    status[PMOC_ST_OTHER] = |(sel & oth_q); // R20
  end

  // on/off byte read back for the first selected rail
  assign rd_idx = (page_q == PMOC_PAGE_ALL) ? '0 : page_q[IDX_W-1:0];
  assign op_rd  = op_on_q[rd_idx] ? PMOC_OP_RD_ON :
                  (op_imm_q[rd_idx] ? PMOC_OP_RD_IMM : PMOC_OP_RD_SOFT);

  // read answer one cycle after the request
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
    end else begin
      rd_valid_q <= rd;
      if (rd) begin
        case (cmd_code_in)
          PMOC_CODE_PAGE: rd_data_q <= page_q;
          PMOC_CODE_OP:   rd_data_q <= op_rd;
          PMOC_CODE_WP:   rd_data_q <= wp_q;
          PMOC_CODE_CAP:  rd_data_q <= PMOC_CAP_VALUE; // R17
          PMOC_CODE_STAT: rd_data_q <= status; // R18
          PMOC_CODE_DLY:  rd_data_q <= dly_q;
          default:        rd_data_q <= '0;
        endcase
      end
    end
  end

  // registered rail state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rail_en_q  <= '0;
      rail_off_q <= '1;
    end else begin
      rail_en_q  <= on_w;
      rail_off_q <= ~on_w; // R10
    end
  end

  // ==========================================================
  // outputs
  assign rd_valid_out    = rd_valid_q;
  assign rd_data_out     = rd_data_q;
  assign rail_enable_out = rail_en_q;
  assign rail_off_out    = rail_off_q;
  assign store_busy_out  = store_busy_q;
  assign stored_out      = nv_valid_q;

endmodule : pmoc_ctrl

//--- pmoc_pkg.sv
// package: command codes, field layouts, reset values and timing for rail on/off control
package pmoc_pkg;

  // ==========================================================
  // command codes
  localparam logic [7:0] PMOC_CODE_PAGE  = 8'h00;
  localparam logic [7:0] PMOC_CODE_OP    = 8'h01;
  localparam logic [7:0] PMOC_CODE_CLR   = 8'h03;
  localparam logic [7:0] PMOC_CODE_WP    = 8'h10;
  localparam logic [7:0] PMOC_CODE_STORE = 8'h11;
  localparam logic [7:0] PMOC_CODE_CAP   = 8'h19;
  localparam logic [7:0] PMOC_CODE_STAT  = 8'h78;
  localparam logic [7:0] PMOC_CODE_VREF  = 8'hd8;
  localparam logic [7:0] PMOC_CODE_DLY   = 8'hdd;

  // ==========================================================
  // page selector
  localparam logic [7:0] PMOC_PAGE_ALL   = 8'hff;
  localparam logic [7:0] PMOC_PAGE_RESET = 8'hff;

  // ==========================================================
  // write lock levels
  localparam logic [7:0] PMOC_WP_ONLY  = 8'h80;
  localparam logic [7:0] PMOC_WP_OPPG  = 8'h40;
  localparam logic [7:0] PMOC_WP_VREF  = 8'h20;
  localparam logic [7:0] PMOC_WP_NONE  = 8'h00;
  localparam logic [7:0] PMOC_WP_RESET = 8'h40;

  // ==========================================================
  // on/off control byte layout
  localparam int         PMOC_OP_TOP_HI = 7;
  localparam int         PMOC_OP_TOP_LO = 6;
  localparam int         PMOC_OP_MID_HI = 5;
  localparam int         PMOC_OP_MID_LO = 4;
  localparam logic [1:0] PMOC_OP_IMM    = 2'h0;
  localparam logic [1:0] PMOC_OP_SOFT   = 2'h1;
  localparam logic [1:0] PMOC_OP_ON     = 2'h2;
  localparam logic [1:0] PMOC_OP_MID_ON = 2'h0;
  localparam logic [7:0] PMOC_OP_RESET  = 8'h80;
  localparam logic [7:0] PMOC_OP_RD_ON  = 8'h80;
  localparam logic [7:0] PMOC_OP_RD_SOFT = 8'h40;
  localparam logic [7:0] PMOC_OP_RD_IMM = 8'h00;

  // ==========================================================
  // feature report fields
  localparam logic       PMOC_CAP_PEC   = 1'h1;
  localparam logic [1:0] PMOC_CAP_SPEED = 2'h1;
  localparam logic       PMOC_CAP_ALERT = 1'h0;
  localparam logic [3:0] PMOC_CAP_RSVD  = 4'h0;
  localparam logic [7:0] PMOC_CAP_VALUE = {PMOC_CAP_PEC, PMOC_CAP_SPEED,
                                           PMOC_CAP_ALERT, PMOC_CAP_RSVD};

  // ==========================================================
  // fault summary bit positions
  localparam int PMOC_ST_OFF   = 6;
  localparam int PMOC_ST_OV    = 5;
  localparam int PMOC_ST_OC    = 4;
  localparam int PMOC_ST_TEMP  = 2;
  localparam int PMOC_ST_CML   = 1;
  localparam int PMOC_ST_OTHER = 0;

  // ==========================================================
  // turn-on/off delay setting layout
  localparam int         PMOC_DLY_ON_HI  = 5;
  localparam int         PMOC_DLY_ON_LO  = 3;
  localparam int         PMOC_DLY_OFF_HI = 2;
  localparam int         PMOC_DLY_OFF_LO = 0;
  localparam logic [7:0] PMOC_DLY_RESET  = 8'h01;

  // ==========================================================
  // timing
  localparam int PMOC_CLK_PERIOD_NS = 10;
  localparam int PMOC_NS_PER_MS     = 1000000;
  localparam int PMOC_DLY_STEP_MS   = 1;
  localparam int PMOC_STORE_MAX_MS  = 70;
  localparam int PMOC_DLY_STEP_CYC  = PMOC_DLY_STEP_MS * PMOC_NS_PER_MS / PMOC_CLK_PERIOD_NS;
  localparam int PMOC_STORE_CYC     = PMOC_STORE_MAX_MS * PMOC_NS_PER_MS / PMOC_CLK_PERIOD_NS;
  localparam int PMOC_CNT_W         = 24;

  // ==========================================================
  // rail sequencer states
  typedef enum logic [3:0] {
    PMOC_R_OFF  = 4'h1,
    PMOC_R_ONW  = 4'h2,
    PMOC_R_ON   = 4'h4,
    PMOC_R_OFFW = 4'h8
  } pmoc_rail_st_t;

endpackage : pmoc_pkg

//--- pmoc_rail_if.sv
// interface: controller to single rail sequencer
`timescale 1ns/1ps
interface pmoc_rail_if;
  import pmoc_pkg::*;
  logic                  want;
  logic                  imm_off;
  logic                  block;
  logic [PMOC_CNT_W-1:0] ton_cyc;
  logic [PMOC_CNT_W-1:0] toff_cyc;
  logic                  is_on;

  modport ctrl (output want, imm_off, block, ton_cyc, toff_cyc, input is_on);
  modport rail (input want, imm_off, block, ton_cyc, toff_cyc, output is_on);
endinterface : pmoc_rail_if

//--- pmoc_rail.sv
// module: per-rail on/off sequencer with turn-on and turn-off delays
`timescale 1ns/1ps
module pmoc_rail
  import pmoc_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // controller side
  pmoc_rail_if.rail rif
);

  pmoc_rail_st_t         state_q;
  logic [PMOC_CNT_W-1:0] cnt_q;

  // ==========================================================
  // state machine
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= PMOC_R_OFF;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        PMOC_R_OFF: begin
          if (rif.want && !rif.block) begin
            state_q <= PMOC_R_ONW; // R5
            cnt_q   <= rif.ton_cyc;
          end
        end
        PMOC_R_ONW: begin
          if (rif.block || !rif.want) begin
            state_q <= PMOC_R_OFF;        // R6
          end else if (cnt_q == '0) begin
            state_q <= PMOC_R_ON;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        PMOC_R_ON: begin
          if (rif.block || (!rif.want && rif.imm_off)) begin
            state_q <= PMOC_R_OFF;        // R6
          end else if (!rif.want) begin
            state_q <= PMOC_R_OFFW; // R5
            cnt_q   <= rif.toff_cyc;
          end
        end
        PMOC_R_OFFW: begin
          if (rif.block) begin
            state_q <= PMOC_R_OFF;        // R6
          end else if (rif.want) begin
            state_q <= PMOC_R_ON;
          end else if (cnt_q == '0) begin
            state_q <= PMOC_R_OFF;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: begin
          state_q <= PMOC_R_OFF;
        end
      endcase
    end
  end

  // rail conducts while on or winding down
  assign rif.is_on = (state_q == PMOC_R_ON) || (state_q == PMOC_R_OFFW);

endmodule : pmoc_rail

//--- pmoc_ctrl_sva.sv
// checker: port-level properties of rail on/off control
`timescale 1ns/1ps
module pmoc_ctrl_sva
  import pmoc_pkg::*;
#(
  parameter int NUM_RAILS = 4,
  parameter int STORE_CYC = 8
) (
  // clock and reset
  input wire logic                 clk_in,
  input wire logic                 reset_in,
  // command port and answer
  input wire logic                 cmd_valid_in,
  input wire logic                 cmd_write_in,
  input wire logic [7:0]           cmd_code_in,
  input wire logic [7:0]           cmd_data_in,
  input wire logic                 rd_valid_out,
  input wire logic [7:0]           rd_data_out,
  // pins, faults and rail state
  input wire logic                 pins_honoured_in,
  input wire logic [NUM_RAILS-1:0] ov_fault_in,
  input wire logic                 temp_fault_in,
  input wire logic [NUM_RAILS-1:0] rail_enable_out,
  input wire logic [NUM_RAILS-1:0] rail_off_out,
  input wire logic                 store_busy_out,
  input wire logic                 stored_out
);
  // ==========================================================
  // helper state
  logic all_q;
  logic [7:0] wp_q;
  int busy_q;
  wire wr_w = cmd_valid_in && cmd_write_in;
  wire rd_w = cmd_valid_in && !cmd_write_in;
  // page-all flag and lock level as writes leave them
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      all_q <= 1'b1;
      wp_q <= PMOC_WP_RESET;
    end else if (wr_w && cmd_code_in == PMOC_CODE_WP) begin
      if ($onehot0(cmd_data_in) && cmd_data_in[4:0] == 5'h00) wp_q <= cmd_data_in;
    end else if (wr_w && cmd_code_in == PMOC_CODE_PAGE && wp_q != PMOC_WP_ONLY) begin
      if (cmd_data_in < 8'h04 || cmd_data_in == PMOC_PAGE_ALL) all_q <= &cmd_data_in;
    end
  end
  // counts cycles the store stays busy
  always_ff @(posedge clk_in) begin
    busy_q <= (store_busy_out && !reset_in) ? busy_q + 1 : 0;
  end
  // ==========================================================
  // properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_rd(logic [7:0] c);
    rd_w && cmd_code_in == c;
  endsequence
  sequence s_store;
    wr_w && cmd_code_in == PMOC_CODE_STORE && !store_busy_out;
  endsequence
  sequence s_imm_all;
    wr_w && cmd_code_in == PMOC_CODE_OP && cmd_data_in[7:6] == PMOC_OP_IMM && all_q
      && wp_q != PMOC_WP_ONLY && !pins_honoured_in ##1 (!wr_w && !pins_honoured_in)[*2];
  endsequence
  chk_imm_all_off: assert property (s_imm_all |-> ##[0:1] rail_enable_out == '0)
    else $error("immediate off left a rail on");
  chk_fault_rail_off: assert property (|ov_fault_in |->
    ##2 (rail_enable_out & $past(ov_fault_in, 2)) == '0)
    else $error("faulted rail still enabled");
  chk_off_tracks_on: assert property (rail_off_out == ~rail_enable_out)
    else $error("off indication differs from rail state");
  chk_store_starts: assert property (s_store |=> store_busy_out && stored_out)
    else $error("store did not start");
  chk_store_bound: assert property (store_busy_out |-> busy_q <= STORE_CYC)
    else $error("store busy too long");
  chk_feature_byte: assert property (s_rd(PMOC_CODE_CAP) |=>
    rd_valid_out && rd_data_out == 8'ha0)
    else $error("feature byte wrong");
  chk_status_rsvd: assert property (s_rd(PMOC_CODE_STAT) |=>
    rd_valid_out && !rd_data_out[7] && !rd_data_out[3])
    else $error("status reserved bits set");
  chk_temp_global: assert property (rd_w && cmd_code_in == PMOC_CODE_STAT && temp_fault_in
    && $past(temp_fault_in) && !$past(reset_in) |=> rd_data_out[PMOC_ST_TEMP])
    else $error("temperature bit missing");
endmodule : pmoc_ctrl_sva

bind pmoc_ctrl pmoc_ctrl_sva #(.NUM_RAILS(NUM_RAILS), .STORE_CYC(STORE_CYC)) pmoc_ctrl_sva_i (.*);

//--- pmoc_host.sv
// partner: command-issuing host on the command port
`timescale 1ns/1ps
module pmoc_host (
  // clock and answer
  input  wire logic       clk_in,
  input  wire logic       store_busy_out,
  input  wire logic       rd_valid_out,
  input  wire logic [7:0] rd_data_out,
  // command port
  output logic            cmd_valid_in = 1'b0,
  output logic            cmd_write_in = 1'b0,
  output logic [7:0]      cmd_code_in = 8'h00,
  output logic [7:0]      cmd_data_in = 8'h00
);
  // one command, driven after a falling edge; lines scrambled once released
  task automatic send(input logic w, input logic [7:0] c, input logic [7:0] d);
    while (w && store_busy_out) @(negedge clk_in);
    @(negedge clk_in);
    cmd_valid_in = 1'b1;
    cmd_write_in = w;
    cmd_code_in = c;
    cmd_data_in = d;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    cmd_code_in = ~c;
    cmd_data_in = ~d;
  endtask : send
  // read: answer pulse follows the taking edge
  task automatic rd(input logic [7:0] c, output logic [7:0] q);
    send(1'b0, c, 8'h00);
    if (rd_valid_out !== 1'b1) @(negedge clk_in);
    q = rd_data_out;
  endtask : rd
endmodule : pmoc_host

//--- tb_pmoc_ctrl.sv
// testbench: self-checking run of rail on/off control
`timescale 1ns/1ps
module tb_pmoc_ctrl;
  import pmoc_pkg::*;
  // ==========================================================
  // design ports and bench state
  logic       clk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       por_in = 1'b1;
  logic       pins_honoured_in = 1'b0;
  logic       seq_support_in = 1'b1;
  logic       retry_en_in = 1'b0;
  logic       temp_fault_in = 1'b0;
  logic [3:0] rail_enable_pins_in = 4'h0;
  logic [3:0] ov_fault_in = 4'h0;
  logic [3:0] oc_fault_in = 4'h0;
  logic [3:0] other_fault_in = 4'h0;
  logic       cmd_valid_in, cmd_write_in, rd_valid_out, store_busy_out, stored_out;
  logic [7:0] cmd_code_in, cmd_data_in, rd_data_out, q;
  logic [3:0] rail_enable_out, rail_off_out;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         r;
  always #5 clk_in = ~clk_in;
  pmoc_host host_i (.*);
  pmoc_ctrl #(.DLY_STEP_CYC(4), .STORE_CYC(8)) pmoc_ctrl_i (.*);
  // expected status byte: off, overvoltage, temperature, comms
  function automatic logic [7:0] st_exp(logic off, logic ov, logic tmp, logic cml);
    return {1'b0, off, ov, 2'h0, tmp, cml, 1'b0};
  endfunction : st_exp
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] c, input logic [7:0] e, input string n);
    host_i.rd(c, q);
    chk(n, e, q);
  endtask : rdc
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host_i.send(1'b1, c, d);
  endtask : wr
  task automatic close_out;
    $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // watchdog against a hang
  initial begin
    #40000;
    miscompares++;
    $display("MISMATCH watchdog expected end seen hang");
    close_out();
  end
  // main sequence
  initial begin
    r = $urandom(99404);
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    por_in = 1'b0;
    rdc(PMOC_CODE_CAP, 8'ha0, "feature");
    rdc(PMOC_CODE_WP, 8'h40, "lock reset");
    rdc(PMOC_CODE_PAGE, 8'hff, "page reset");
    repeat (20) @(negedge clk_in);
    chk("rails up", 8'h0f, {4'h0, rail_enable_out});
    rdc(PMOC_CODE_STAT, st_exp(0, 0, 0, 0), "status on");
    wr(PMOC_CODE_OP, 8'h3c);
    repeat (3) @(negedge clk_in);
    chk("imm off", 8'h00, {4'h0, rail_enable_out});
    rdc(PMOC_CODE_STAT, st_exp(1, 0, 0, 0), "status off");
    $display("test on/off done");
    r = $urandom;
    rail_enable_pins_in = r[3:0];
    pins_honoured_in = 1'b1;
    repeat (10) @(negedge clk_in);
    chk("pins on", {4'h0, r[3:0]}, {4'h0, rail_enable_out});
    pins_honoured_in = 1'b0;
    repeat (12) @(negedge clk_in);
    chk("pins ignored", 8'h00, {4'h0, rail_enable_out});
    wr(PMOC_CODE_PAGE, 8'h02);
    wr(PMOC_CODE_OP, 8'h80);
    repeat (5) @(negedge clk_in);
    chk("page rail", 8'h04, {4'h0, rail_enable_out});
    wr(PMOC_CODE_WP, 8'h80);
    wr(PMOC_CODE_OP, 8'h00);
    repeat (3) @(negedge clk_in);
    chk("locked op", 8'h04, {4'h0, rail_enable_out});
    rdc(PMOC_CODE_STAT, st_exp(0, 0, 0, 1), "comms set");
    wr(PMOC_CODE_CLR, 8'h00);
    rdc(PMOC_CODE_STAT, st_exp(0, 0, 0, 0), "comms clear");
    wr(PMOC_CODE_WP, 8'h00);
    wr(PMOC_CODE_PAGE, 8'hff);
    wr(PMOC_CODE_OP, 8'h80);
    repeat (20) @(negedge clk_in);
    $display("test lock done");
    r = $urandom % 4;
    ov_fault_in[r] = 1'b1;
    repeat (2) @(negedge clk_in);
    ov_fault_in = 4'h0;
    repeat (3) @(negedge clk_in);
    chk("fault off", 8'h0f & ~(8'h01 << r), {4'h0, rail_enable_out});
    temp_fault_in = 1'b1;
    rdc(PMOC_CODE_STAT, st_exp(1, 1, 1, 0), "status all");
    wr(PMOC_CODE_PAGE, 8'(r ^ 1));
    rdc(PMOC_CODE_STAT, st_exp(1, 0, 1, 0), "status other");
    temp_fault_in = 1'b0;
    wr(PMOC_CODE_PAGE, 8'(r));
    wr(PMOC_CODE_CLR, 8'h00);
    rdc(PMOC_CODE_STAT, st_exp(1, 0, 0, 0), "after clear");
    $display("test fault done");
    wr(PMOC_CODE_DLY, 8'h09);
    wr(PMOC_CODE_STORE, 8'h00);
    chk("busy", 8'h03, {6'h0, store_busy_out, stored_out});
    repeat (10) @(negedge clk_in);
    chk("store end", 8'h01, {6'h0, store_busy_out, stored_out});
    reset_in = 1'b1;
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    rdc(PMOC_CODE_WP, 8'h40, "lock kept out");
    rdc(PMOC_CODE_DLY, 8'h09, "delay reload");
    $display("test store done");
    close_out();
  end
endmodule : tb_pmoc_ctrl
